/* File: hdl/event_counter_defs.svh */
// Constants for the signed event counter: widths, reset values, limits.
// Assumes inclusion by bare name from any file that needs them.
`ifndef EVENT_COUNTER_DEFS_SVH
`define EVENT_COUNTER_DEFS_SVH
`define CNT_W 32
`define STAMP_W 48
`define CNT_ZERO 32'h0000_0000
`define CNT_MAX 32'h7fff_ffff
`define CNT_MIN 32'h8000_0000
`define STAMP_ZERO 48'h0000_0000_0000
`endif

/* File: hdl/event_counter_pkg.sv */
// Types shared by the event counter files.
// Assumes the defs header is on the include path.
`include "event_counter_defs.svh"
package event_counter_pkg;
   typedef logic signed [`CNT_W-1:0] count_t;
   typedef logic [`STAMP_W-1:0] stamp_t;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_RUN = 2'b01
   } run_state_e;
endpackage

/* File: hdl/edge_pulse.sv */
// Rising-edge detector for one operand bit.
// Assumes the operand is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module edge_pulse (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic level,
   output logic rise
);
   logic prev_q;

   // Previous level; reset low so an operand high at reset gives one rise, which the counter, still off then, does not count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end

   assign rise = level & ~prev_q;
endmodule
`default_nettype wire

/* File: hdl/event_counter.sv */
// Signed event counter with compare, preset, block and freeze capture.
// Assumes operands synchronous to clk and power-loss save handled outside.
// Notes on behaviour
// - count up by one only on a rising edge of the up operand.
// - count down by one only on a rising edge of the down operand.
// - up at the top positive value wraps to the most negative value.
// - down at the most negative value wraps to the top positive value.
// - above, equal, under flags against compare value; exactly one asserted while enabled and not blocked.
// - while blocked, counting stops and every output flag is held low.
// - on enabling, load preset if preset select is high, else zero.
// - while running, preset select rising loads preset; falling does nothing.
// - reset or freeze-reset loads preset if select high, else zero.
// - freeze-reset captures count and time, then loads count as a reset does.
// - freeze-continue captures count and time while counting goes on.
// - present count, frozen count and frozen stamp are readable outputs.
// - power-down save request copies live count and frozen count to storage.
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_defs.svh"
module event_counter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic count_up,
   input wire logic count_down,
   input wire logic block,
   input wire logic preset_select,
   input wire logic reset_cmd,
   input wire logic freeze_reset,
   input wire logic freeze_count,
   input wire event_counter_pkg::count_t preset_value,
   input wire event_counter_pkg::count_t compare_value,
   input wire event_counter_pkg::stamp_t time_now,
   input wire logic power_fail,
   output event_counter_pkg::count_t count_value,
   output event_counter_pkg::count_t frozen_value,
   output event_counter_pkg::stamp_t frozen_stamp,
   output logic count_above,
   output logic count_equal,
   output logic count_under,
   output event_counter_pkg::count_t saved_count,
   output event_counter_pkg::count_t saved_frozen,
   output logic save_strobe
);
   import event_counter_pkg::*;

   run_state_e state_q, state_d;
   count_t count_q, count_d;
   count_t frozen_q;
   stamp_t stamp_q;
   logic above_q, equal_q, under_q;
   count_t save_cnt_q, save_frz_q;
   logic save_q;
   logic up_rise, down_rise, psel_rise, pf_rise;
   wire logic [3:0] op_rise;

   // Operand levels gathered so one loop builds every rising-edge detector
   wire logic [3:0] op_level = {power_fail, preset_select, count_down, count_up};

   // One shared detector module keeps edge handling identical everywhere
   for (genvar i = 0; i < 4; i++) begin : g_edge
      edge_pulse u_edge_pulse (
         .clk(clk),
         .rst_n(rst_n),
         .level(op_level[i]),
         .rise(op_rise[i])
      );
   end

   // Fixed bit order: up, down, preset select, power fail
   assign up_rise = op_rise[0];
   assign down_rise = op_rise[1];
   assign psel_rise = op_rise[2];
   assign pf_rise = op_rise[3];

   // Event decode
   wire logic running = (state_q == ST_RUN) && enable;
   wire logic starting = (state_q == ST_OFF) && enable;
   wire logic counting = running && !block;
   wire logic inc = counting && up_rise && !down_rise;
   wire logic dec = counting && down_rise && !up_rise;
   wire logic do_reset = running && (reset_cmd || freeze_reset);
   wire logic do_freeze = running && (freeze_reset || freeze_count);
   wire count_t load_val = preset_select ? preset_value : count_t'(`CNT_ZERO);
   // Plain two's-complement add wraps at the limits by itself
   wire count_t up_val = count_t'(count_q + count_t'(1));
   wire count_t down_val = count_t'(count_q - count_t'(1));

   // Next count: loads take priority over counting in the same cycle
   always_comb begin
      count_d = count_q;
      state_d = enable ? ST_RUN : ST_OFF;
      if (starting) begin
         count_d = load_val;
      end else if (do_reset) begin
         count_d = load_val;
      end else if (running && psel_rise) begin
         count_d = preset_value;
      end else if (inc) begin
         count_d = up_val;
      end else if (dec) begin
         count_d = down_val;
      end
   end

   // Compare flags against the next count so flags track count_value
   wire logic cmp_gt = count_d > compare_value;
   wire logic cmp_eq = count_d == compare_value;
   wire logic show = enable && !block;

   // Count, state and compare outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_OFF;
         count_q <= `CNT_ZERO;
         above_q <= 1'b0;
         equal_q <= 1'b0;
         under_q <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         above_q <= show && cmp_gt;
         equal_q <= show && cmp_eq;
         under_q <= show && !cmp_gt && !cmp_eq;
      end
   end

   // Freeze capture takes the count before any reset in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frozen_q <= `CNT_ZERO;
         stamp_q <= `STAMP_ZERO;
      end else if (do_freeze) begin
         frozen_q <= count_q;
         stamp_q <= time_now;
      end
   end

   // Power-fail snapshot for the external non-volatile store
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         save_cnt_q <= `CNT_ZERO;
         save_frz_q <= `CNT_ZERO;
         save_q <= 1'b0;
      end else begin
         save_q <= pf_rise;
         if (pf_rise) begin
            save_cnt_q <= count_q;
            save_frz_q <= frozen_q;
         end
      end
   end

   assign count_value = count_q;
   assign frozen_value = frozen_q;
   assign frozen_stamp = stamp_q;
   assign count_above = above_q;
   assign count_equal = equal_q;
   assign count_under = under_q;
   assign saved_count = save_cnt_q;
   assign saved_frozen = save_frz_q;
   assign save_strobe = save_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   up_count_a: assert property (inc && !starting && !do_reset && !psel_rise |=>
      count_value == $past(count_value) + 32'sd1) else $error("up edge did not add one");
   down_count_a: assert property (dec && !starting && !do_reset && !psel_rise |=>
      count_value == $past(count_value) - 32'sd1) else $error("down edge did not subtract one");
   up_wrap_a: assert property (inc && !starting && !do_reset && !psel_rise
      && count_value == `CNT_MAX |=> count_value == `CNT_MIN) else $error("up wrap wrong");
   down_wrap_a: assert property (dec && !starting && !do_reset && !psel_rise
      && count_value == `CNT_MIN |=> count_value == `CNT_MAX) else $error("down wrap wrong");
   one_flag_a: assert property ($past(show) && $past(rst_n) |->
      $onehot({count_above, count_equal, count_under})) else $error("compare flags not one-hot");
   block_quiet_a: assert property (block |=>
      !count_above && !count_equal && !count_under) else $error("flags active while blocked");
   enable_load_a: assert property (starting |=>
      count_value == $past(load_val)) else $error("enable load wrong");
   preset_edge_a: assert property (running && psel_rise && !do_reset |=>
      count_value == $past(preset_value)) else $error("preset edge not loaded");
   reset_load_a: assert property (do_reset |=>
      count_value == $past(load_val)) else $error("reset load wrong");
   freeze_reset_a: assert property (running && freeze_reset |=>
      frozen_value == $past(count_value) && frozen_stamp == $past(time_now))
      else $error("freeze capture wrong");
   freeze_cont_a: assert property (running && freeze_count && !freeze_reset && !reset_cmd
      && inc && !psel_rise |=> count_value == frozen_value + 32'sd1)
      else $error("freeze continue stopped counting");
   both_edges_a: assert property (running && up_rise && down_rise && !do_reset && !psel_rise
      |=> $stable(count_value)) else $error("simultaneous edges changed count");
   save_snap_a: assert property (pf_rise |=> save_strobe
      && saved_count == $past(count_value)) else $error("power save snapshot wrong");

   // Hold checks, plus the freeze-reset clear: without an event or a load nothing may move
   no_edge_hold_a: assert property (running && !up_rise && !down_rise
      && !do_reset && !psel_rise |=> $stable(count_value))
      else $error("count moved without an edge");
   block_hold_a: assert property (running && block && !do_reset
      && !psel_rise |=> $stable(count_value)) else $error("count moved while blocked");
   off_hold_a: assert property (!enable |=> $stable(count_value)
      && !count_above && !count_equal && !count_under)
      else $error("disabled counter changed");
   fall_quiet_a: assert property (running && $fell(preset_select) && !do_reset
      && !inc && !dec |=> $stable(count_value)) else $error("select fall moved count");
   freeze_clear_a: assert property (running && freeze_reset && !preset_select
      |=> count_value == `CNT_ZERO) else $error("freeze reset did not clear");
   freeze_hold_a: assert property (!do_freeze |=> $stable(frozen_value)
      && $stable(frozen_stamp)) else $error("frozen values moved without a freeze");
   // The store only latches on a strobe edge, so a long strobe would be harmless but wrong
   strobe_pulse_a: assert property (save_strobe |=> !save_strobe)
      else $error("save strobe longer than one cycle");

   wrap_up_c: cover property (inc && count_value == `CNT_MAX);
   freeze_c: cover property (running && freeze_reset);
   block_c: cover property (running && block && up_rise);
   preset_c: cover property (running && psel_rise);
   freeze_cont_c: cover property (running && freeze_count && inc);
endmodule
`default_nettype wire

/* File: sim/operand_source.sv */
// Model of the protection logic that feeds the counter's operand levels.
// Assumes one clock shared with the counter; the bench issues requests.
`timescale 1ns/1ps
`default_nettype none
module operand_source (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fire_up,
   input wire logic fire_dn,
   output logic up_level,
   output logic dn_level
);
   // One-cycle pulses, so a level is low again before the next rise
   always_ff @(posedge clk) begin
      up_level <= rst_n & fire_up;
      dn_level <= rst_n & fire_dn;
   end
endmodule
`default_nettype wire

/* File: sim/test_event_counter.sv */
// Self-checking bench for the signed event counter.
// Assumes the operand model produces the counting levels.
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_defs.svh"
module test_event_counter;
   import event_counter_pkg::*;
   logic clk = 0, rst_n = 0, enable = 0, block = 0, preset_select = 0, reset_cmd = 0;
   logic freeze_reset = 0, freeze_count = 0, power_fail = 0, fire_up = 0, fire_dn = 0;
   logic up_level, dn_level, count_above, count_equal, count_under, save_strobe;
   count_t preset_value = 0, compare_value = 0, count_value, frozen_value;
   count_t saved_count, saved_frozen;
   stamp_t time_now = 0, frozen_stamp;
   int errors = 0, check_count = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   operand_source u_operand_source (.clk(clk), .rst_n(rst_n), .fire_up(fire_up),
      .fire_dn(fire_dn), .up_level(up_level), .dn_level(dn_level));
   event_counter u_event_counter (.clk(clk), .rst_n(rst_n), .enable(enable),
      .count_up(up_level), .count_down(dn_level), .block(block),
      .preset_select(preset_select), .reset_cmd(reset_cmd), .freeze_reset(freeze_reset),
      .freeze_count(freeze_count), .preset_value(preset_value),
      .compare_value(compare_value), .time_now(time_now), .power_fail(power_fail),
      .count_value(count_value), .frozen_value(frozen_value), .frozen_stamp(frozen_stamp),
      .count_above(count_above), .count_equal(count_equal), .count_under(count_under),
      .saved_count(saved_count), .saved_frozen(saved_frozen), .save_strobe(save_strobe));
   task tick;
      @(posedge clk);
   endtask
   task chk_cnt(string what, count_t exp, count_t got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task chk_flags(logic [2:0] exp);
      check_count++;
      if ({count_above, count_equal, count_under} !== exp) begin
         errors++;
         $display("MISMATCH flags expected %b seen %b", exp,
            {count_above, count_equal, count_under});
      end
   endtask
   task chk_stamp(stamp_t exp);
      check_count++;
      if (frozen_stamp !== exp) begin
         errors++;
         $display("MISMATCH stamp expected %h seen %h", exp, frozen_stamp);
      end
   endtask
   task chk_bit(string what, logic exp, logic got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask
   // Signed compare, so negative counts sit below the compare value
   task expect_cnt(count_t e);
      chk_cnt("count", e, count_value);
      chk_flags({e > compare_value, e == compare_value, e < compare_value});
   endtask
   // Pulse reaches the counter one edge after the request and is counted on the next edge
   task cnt(logic u, logic d);
      tick;
      fire_up <= u;
      fire_dn <= d;
      tick;
      fire_up <= 0;
      fire_dn <= 0;
      tick;
      #1;
   endtask
   task t_load;
      tick;
      enable <= 1;
      compare_value <= 32'h0000_0008;
      tick;
      #1 expect_cnt(32'h0);
      tick;
      enable <= 0;
      preset_select <= 1;
      preset_value <= 32'h0000_0007;
      tick;
      enable <= 1;
      tick;
      #1 expect_cnt(32'h7);
      $display("test load done");
   endtask
   task t_count;
      cnt(1, 0);
      expect_cnt(32'h8);
      cnt(1, 0);
      expect_cnt(32'h9);
      cnt(1, 1);
      expect_cnt(32'h9);
      cnt(0, 1);
      cnt(0, 1);
      expect_cnt(32'h7);
      $display("test count done");
   endtask
   task t_wrap;
      tick;
      preset_select <= 0;
      preset_value <= `CNT_MAX;
      tick;
      preset_select <= 1;
      tick;
      #1 expect_cnt(`CNT_MAX);
      tick;
      preset_select <= 0;
      preset_value <= 32'h0000_0005;
      tick;
      #1 expect_cnt(`CNT_MAX);
      cnt(1, 0);
      expect_cnt(`CNT_MIN);
      cnt(0, 1);
      expect_cnt(`CNT_MAX);
      tick;
      block <= 1;
      cnt(1, 0);
      chk_cnt("count", `CNT_MAX, count_value);
      chk_flags(3'b000);
      tick;
      block <= 0;
      $display("test wrap and block done");
   endtask
   task t_freeze;
      tick;
      time_now <= 48'h0123_4567_89ab;
      freeze_count <= 1;
      tick;
      freeze_count <= 0;
      #1 chk_cnt("frozen", `CNT_MAX, frozen_value);
      chk_stamp(48'h0123_4567_89ab);
      cnt(0, 1);
      expect_cnt(32'h7fff_fffe);
      tick;
      freeze_reset <= 1;
      tick;
      freeze_reset <= 0;
      #1 chk_cnt("frozen", 32'h7fff_fffe, frozen_value);
      expect_cnt(32'h0);
      cnt(1, 0);
      tick;
      reset_cmd <= 1;
      tick;
      reset_cmd <= 0;
      #1 expect_cnt(32'h0);
      tick;
      preset_select <= 1;
      tick;
      #1 expect_cnt(32'h5);
      cnt(1, 0);
      expect_cnt(32'h6);
      tick;
      reset_cmd <= 1;
      tick;
      reset_cmd <= 0;
      #1 expect_cnt(32'h5);
      // Freeze in the cycle of an up edge: old count captured, counting goes on
      tick;
      fire_up <= 1;
      time_now <= 48'h0000_0000_0abc;
      tick;
      fire_up <= 0;
      freeze_count <= 1;
      tick;
      freeze_count <= 0;
      #1 chk_cnt("frozen", 32'h5, frozen_value);
      chk_stamp(48'h0000_0000_0abc);
      expect_cnt(32'h6);
      $display("test freeze done");
   endtask
   task t_power;
      tick;
      power_fail <= 1;
      tick;
      #1 chk_bit("strobe", 1'b1, save_strobe);
      chk_cnt("saved", 32'h6, saved_count);
      chk_cnt("saved_frozen", 32'h5, saved_frozen);
      tick;
      #1 chk_bit("strobe", 1'b0, save_strobe);
      $display("test power done");
   endtask
   // Mid-run reset clears outputs; enabling with select high then loads the preset
   task t_reset;
      tick;
      rst_n <= 0;
      power_fail <= 0;
      tick;
      tick;
      #1 chk_cnt("count", 32'h0, count_value);
      chk_cnt("frozen", 32'h0, frozen_value);
      chk_cnt("saved", 32'h0, saved_count);
      chk_stamp(48'h0);
      chk_flags(3'b000);
      tick;
      rst_n <= 1;
      tick;
      #1 expect_cnt(32'h5);
      $display("test reset done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Main sequence after two cycles of reset
   initial begin
      repeat (2) tick;
      rst_n <= 1;
      t_load;
      t_count;
      t_wrap;
      t_freeze;
      t_power;
      t_reset;
      end_of_test;
   end
   // Watchdog well beyond the 68 cycles the tests need
   initial begin
      repeat (1000) @(posedge clk);
      errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
